// ==== bench/gpio_pin_partner.sv ====
// Model of the circuitry on the package pins.
`timescale 1ns/100ps
module gpio_pin_partner (
  input  wire logic        core_clk,    // Clock.
  input  wire logic [47:0] pin_out,     // Device levels.
  input  wire logic [47:0] pin_oe_n,    // Device drives.
  input  wire logic [47:0] pin_pull_en, // Device pulls.
  input  wire logic [47:0] ext_val,     // Outside levels.
  input  wire logic [47:0] ext_en,      // Outside drives.
  output logic      [47:0] pin_in       // Pin levels.
);
  logic [47:0] float_pat = 48'h0;
  // ==========================================
  // Pin resolution.
  // An undriven pin without pull toggles so no stale level can be read.
  always @(posedge core_clk) begin
    float_pat <= ~float_pat;
  end
  always_comb begin
    pin_in = (ext_en & ext_val) | (~ext_en & ~pin_oe_n & pin_out);
    pin_in = pin_in | (~ext_en & pin_oe_n & (pin_pull_en | float_pat));
  end
endmodule

// ==== bench/gpio_ports_assertions.sv ====
// Port checker for the GPIO block.
`timescale 1ns/100ps
module gpio_ports_assertions (
  input wire logic        core_clk,    // Clock.
  input wire logic        sys_rst,     // Reset.
  input wire logic [5:0]  mem_addr,    // Offset.
  input wire logic        mem_wr,      // Write.
  input wire logic        mem_rd,      // Read.
  input wire logic [7:0]  mem_rdata,   // Data.
  input wire logic        low_power,   // Sleep.
  input wire logic        wake_req,    // Wake.
  input wire logic [47:0] pin_out,     // Levels.
  input wire logic [47:0] pin_oe_n,    // Drives.
  input wire logic [47:0] pin_pull_en, // Pulls.
  input wire logic        pa3_vref_en, // Vref.
  input wire logic        pa2_an4_en,  // Analog.
  input wire logic        pa1_an0_en,  // Analog.
  input wire logic        pa0_an5_en   // Analog.
);
  // ==========================================
  // Checks.
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  reset_state_a: assert property ($past(sys_rst) |-> &pin_oe_n && pin_pull_en == 48'h0)
    else $error("pins not inputs after reset");
  pull_input_a: assert property ((pin_pull_en & ~pin_oe_n) == 48'h0)
    else $error("pull on driven pin");
  port_b_top_a: assert property (pin_oe_n[15] && !pin_pull_en[15])
    else $error("missing pin active");
  unmapped_read_a: assert property (mem_rd && mem_addr == 6'h3f |=> mem_rdata == 8'h00)
    else $error("unmapped read not zero");
  latch_hold_a: assert property (!$past(mem_wr) && !$past(mem_wr, 2) |-> $stable(pin_out[47:8]))
    else $error("latch changed unwritten");
  wake_gate_a: assert property (wake_req |-> low_power || $past(low_power))
    else $error("wake while awake");
  vref_float_a: assert property (pa3_vref_en |-> pin_oe_n[3])
    else $error("vref pin driven");
  an4_float_a: assert property (pa2_an4_en |-> pin_oe_n[2] && !pin_pull_en[2])
    else $error("analog pin driven");
  an0_float_a: assert property (pa1_an0_en |-> pin_oe_n[1] && !pin_pull_en[1])
    else $error("analog pin driven");
  an5_float_a: assert property (pa0_an5_en |-> pin_oe_n[0] && !pin_pull_en[0])
    else $error("analog pin driven");
endmodule
bind gpio_ports gpio_ports_assertions u_gpio_ports_assertions (.core_clk, .sys_rst, .mem_addr, .mem_wr, .mem_rd,
  .mem_rdata, .low_power, .wake_req, .pin_out, .pin_oe_n, .pin_pull_en, .pa3_vref_en, .pa2_an4_en, .pa1_an0_en,
  .pa0_an5_en);

// ==== bench/gpio_ports_test.sv ====
// Self-checking bench for the GPIO block.
`timescale 1ns/100ps
module gpio_ports_test;
  logic        core_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [5:0]  mem_addr = 6'h00;
  logic        mem_wr = 1'b0;
  logic        mem_rd = 1'b0;
  logic [7:0]  mem_wdata = 8'h00;
  logic        low_power = 1'b0;
  logic        serial_out = 1'b0;
  logic        timer0_output = 1'b0;
  logic [47:0] ext_val = 48'hc3a5_0f69_9655;
  logic [47:0] ext_en = 48'hffff_ffff_ffff;
  logic [47:0] pin_in, pin_out, pin_oe_n, pin_pull_en;
  logic [7:0]  mem_rdata, msk, cnt;
  logic [3:0]  sel_exp;
  logic [1:0]  c;
  logic        wake_req, pa3_vref_en, pa2_an4_en, pa1_an0_en, pa0_an5_en, timer0_clock_input, serial_in;
  logic [7:0]  rmask [5] = '{8'h8f, 8'h7e, 8'h3e, 8'h3f, 8'h1b};
  int          error_cnt = 0;
  int          num_checks = 0;

  gpio_ports u_gpio_ports (.core_clk, .sys_rst, .mem_addr, .mem_wr, .mem_rd, .mem_wdata, .mem_rdata, .low_power,
    .wake_req, .pin_in, .pin_out, .pin_oe_n, .pin_pull_en, .pa3_vref_en, .pa2_an4_en, .pa1_an0_en, .pa0_an5_en,
    .serial_out, .timer0_output, .timer0_clock_input, .serial_in);
  gpio_pin_partner u_gpio_pin_partner (.core_clk, .pin_out, .pin_oe_n, .pin_pull_en, .ext_val, .ext_en, .pin_in);

  // ==========================================
  // Access and compare tasks.
  task automatic cmp(input string what, input logic [47:0] exp, input logic [47:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge core_clk);
    mem_addr = a;
    mem_wdata = d;
    mem_wr = 1'b1;
    @(negedge core_clk);
    mem_wr = 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    @(negedge core_clk);
    mem_addr = a;
    mem_rd = 1'b1;
    @(negedge core_clk);
    mem_rd = 1'b0;
    cmp("rdata", 48'(e), 48'(mem_rdata));
  endtask
  task automatic wake_count(input int b, input logic [7:0] e);
    ext_val[b] = 1'b0;
    cnt = 8'h00;
    repeat (8) begin
      @(negedge core_clk);
      cnt = cnt + 8'(wake_req);
    end
    cmp("wake", 48'(e), 48'(cnt));
  endtask
  task automatic tally_and_finish;
    if (error_cnt == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ==========================================
  // Stimulus.
  initial begin
    forever #25 core_clk = ~core_clk;
  end
  initial begin
    repeat (8) @(negedge core_clk);
    sys_rst = 1'b0;
    cmp("pulls", 48'h0, pin_pull_en);
    rd(6'h00, 8'h00);
    for (int p = 0; p < 6; p++) begin
      msk = (p == 1) ? 8'h7f : 8'hff;
      rd(6'(1 + 3 * p), 8'h00);
      rd(6'(3 + 3 * p), msk);
      rd(6'(2 + 3 * p), ext_val[8 * p +: 8] & msk);
      wr(6'(1 + 3 * p), 8'hff);
      rd(6'(1 + 3 * p), msk);
    end
    cmp("pulls", 48'hffff_ffff_7fff, pin_pull_en);
    for (int i = 0; i < 12; i++) begin
      rd(6'(32 + i), 8'h00);
      wr(6'(32 + i), 8'hff);
      rd(6'(32 + i), (i == 3) ? 8'h3f : 8'hff);
      wr(6'(32 + i), 8'h00);
    end
    for (int i = 0; i < 5; i++) begin
      rd(6'(48 + i), 8'h00);
      wr(6'(48 + i), 8'hff);
      rd(6'(48 + i), rmask[i]);
      wr(6'(48 + i), 8'h00);
    end
    wr(6'h3f, 8'hff);
    rd(6'h3f, 8'h00);
    // Port c drives a5 while the outside forces 69 onto the pins.
    wr(6'h08, 8'ha5);
    wr(6'h09, 8'h00);
    repeat (2) @(negedge core_clk);
    cmp("port c", 48'ha5_00_00, {24'h0, pin_out[23:16], pin_oe_n[23:16], pin_pull_en[23:16]});
    rd(6'h08, 8'ha5);
    wr(6'h09, 8'hff);
    ext_val[23:16] = 8'h3c;
    repeat (3) @(negedge core_clk);
    rd(6'h08, 8'h3c);
    // The outside lets go of port c, so only the enabled pull-ups hold the pins.
    ext_en[23:16] = 8'h00;
    repeat (3) @(negedge core_clk);
    rd(6'h08, 8'hff);
    wr(6'h09, 8'h00);
    repeat (2) @(negedge core_clk);
    cmp("latch", 48'ha5, 48'(pin_out[23:16]));
    cmp("pin c", 48'ha5, 48'(pin_in[23:16]));
    wr(6'h02, 8'h02);
    wr(6'h03, 8'h00);
    for (int k = 0; k < 4; k++) begin
      c = 2'(k);
      serial_out = (c != 2'h1);
      timer0_output = (c != 2'h2);
      sel_exp = {c == 2'h2, {3{c == 2'h3}}};
      wr(6'h20, {4{c}});
      repeat (2) @(negedge core_clk);
      cmp("analog", 48'(sel_exp), 48'({pa3_vref_en, pa2_an4_en, pa1_an0_en, pa0_an5_en}));
      cmp("oe", 48'(sel_exp), 48'(pin_oe_n[3:0]));
      if (k < 3)
        cmp("pin1", 48'(k == 0), 48'(pin_out[1]));
    end
    wr(6'h20, 8'h00);
    ext_val = 48'h0000_0000_00ff;
    wr(6'h03, 8'hff);
    repeat (4) @(negedge core_clk);
    cmp("route", 48'h3, 48'({timer0_clock_input, serial_in}));
    wr(6'h31, 8'h02);
    wr(6'h26, 8'h10);
    wr(6'h33, 8'h10);
    repeat (4) @(negedge core_clk);
    cmp("route", 48'h0, 48'({timer0_clock_input, serial_in}));
    wr(6'h00, 8'h21);
    rd(6'h00, 8'h21);
    low_power = 1'b1;
    wake_count(5, 8'h01);
    wake_count(1, 8'h00);
    low_power = 1'b0;
    wake_count(0, 8'h00);
    sys_rst = 1'b1;
    repeat (2) @(negedge core_clk);
    sys_rst = 1'b0;
    rd(6'h09, 8'hff);
    rd(6'h00, 8'h00);
    tally_and_finish();
  end
endmodule

// ==== design/gpio_pkg.sv ====
// Package with register offsets, reset values and selector codes for the GPIO block.
package gpio_pkg;
  // ==========================================
  // Register offsets in the local data-memory window.
  localparam logic [5:0] OFF_PA_WAKE   = 6'h00;
  localparam logic [5:0] OFF_PA_PULL   = 6'h01;
  localparam logic [5:0] OFF_PA_DATA   = 6'h02;
  localparam logic [5:0] OFF_PA_DIR    = 6'h03;
  localparam logic [5:0] OFF_PB_PULL   = 6'h04;
  localparam logic [5:0] OFF_PB_DATA   = 6'h05;
  localparam logic [5:0] OFF_PB_DIR    = 6'h06;
  localparam logic [5:0] OFF_PC_PULL   = 6'h07;
  localparam logic [5:0] OFF_PC_DATA   = 6'h08;
  localparam logic [5:0] OFF_PC_DIR    = 6'h09;
  localparam logic [5:0] OFF_PD_PULL   = 6'h0a;
  localparam logic [5:0] OFF_PD_DATA   = 6'h0b;
  localparam logic [5:0] OFF_PD_DIR    = 6'h0c;
  localparam logic [5:0] OFF_PE_PULL   = 6'h0d;
  localparam logic [5:0] OFF_PE_DATA   = 6'h0e;
  localparam logic [5:0] OFF_PE_DIR    = 6'h0f;
  localparam logic [5:0] OFF_PF_PULL   = 6'h10;
  localparam logic [5:0] OFF_PF_DATA   = 6'h11;
  localparam logic [5:0] OFF_PF_DIR    = 6'h12;
  localparam logic [5:0] OFF_SEL_BASE  = 6'h20;
  localparam logic [5:0] OFF_ROUTE_BASE = 6'h30;
  localparam int         NUM_SEL       = 12;
  localparam int         NUM_ROUTE     = 5;
  localparam int         NUM_PORTS     = 6;
  // ==========================================
  // Reset values and write masks.
  localparam logic [7:0] RST_ZERO      = 8'h00;
  localparam logic [7:0] RST_ONES      = 8'hff;
  localparam logic [7:0] RST_PB_DATA   = 8'h0f;
  localparam logic [7:0] PB_MASK       = 8'h7f;
  localparam logic [7:0] FULL_MASK     = 8'hff;
  localparam logic [7:0] PORT_B_FUNC_SEL_HIGH_MASK     = 8'h3f;
  localparam logic [7:0] ROUTE0_MASK   = 8'h8f;
  localparam logic [7:0] ROUTE1_MASK   = 8'h7e;
  localparam logic [7:0] ROUTE2_MASK   = 8'h3e;
  localparam logic [7:0] ROUTE3_MASK   = 8'h3f;
  localparam logic [7:0] ROUTE4_MASK   = 8'h1b;
  // ==========================================
  // Selector codes and field positions of the first port, low selector, and route bit positions.
  localparam logic [1:0] SEL_GPIO      = 2'h0;
  localparam logic [1:0] SEL_F1        = 2'h1;
  localparam logic [1:0] SEL_F2        = 2'h2;
  localparam logic [1:0] SEL_F3        = 2'h3;
  localparam int         PIN3_LSB      = 6;
  localparam int         PIN2_LSB      = 4;
  localparam int         PIN1_LSB      = 2;
  localparam int         PIN0_LSB      = 0;
  localparam int         ROUTE1_TCK0   = 1;
  localparam int         ROUTE3_SDI    = 4;
endpackage

// ==== design/gpio_ports.sv ====
// Six GPIO ports with pull-ups, first-port wake-up and pin-function selectors that act on first-port pins 0 to 3 only.
`timescale 1ns/100ps
module gpio_ports (
  input  wire logic        core_clk,      // System clock, 20 MHz.
  input  wire logic        sys_rst,       // Synchronous reset, active high.
  input  wire logic [5:0]  mem_addr,      // Register offset.
  input  wire logic        mem_wr,        // Write strobe.
  input  wire logic        mem_rd,        // Read strobe, the sampling point.
  input  wire logic [7:0]  mem_wdata,     // Write data.
  output logic      [7:0]  mem_rdata,     // Read data, valid the cycle after mem_rd.
  input  wire logic        low_power,     // Core is in sleep or idle.
  output logic             wake_req,      // Wake-up request to power control.
  input  wire logic [47:0] pin_in,        // Pin levels, port a in the low byte.
  output logic      [47:0] pin_out,       // Pin output levels.
  output logic      [47:0] pin_oe_n,      // Output enable, low while driving.
  output logic      [47:0] pin_pull_en,   // Weak pull-up enables.
  output logic             pa3_vref_en,   // First-port pin 3 routed to vref.
  output logic             pa2_an4_en,    // First-port pin 2 routed to analog four.
  output logic             pa1_an0_en,    // First-port pin 1 routed to analog zero.
  output logic             pa0_an5_en,    // First-port pin 0 routed to analog five.
  input  wire logic        serial_out,    // Serial data output from the serial unit.
  input  wire logic        timer0_output, // Timer 0 compare output.
  output logic             timer0_clock_input, // Routed timer 0 clock input.
  output logic             serial_in      // Routed serial data or SDA input.
);
  logic [7:0] pull_reg   [gpio_pkg::NUM_PORTS];
  logic [7:0] data_reg   [gpio_pkg::NUM_PORTS];
  logic [7:0] dir_reg    [gpio_pkg::NUM_PORTS];
  logic [7:0] wake_reg;
  logic [7:0] sel_reg    [gpio_pkg::NUM_SEL];
  logic [7:0] route_reg  [gpio_pkg::NUM_ROUTE];
  logic [47:0] sync1_reg;
  logic [47:0] sync2_reg;
  logic [7:0]  rdata_next;
  logic [47:0] out_next;
  logic [47:0] oe_n_next;
  logic [47:0] pull_next;

  // ==========================================
  // Helpers.
  function automatic logic [7:0] port_mask(input int p);
    return (p == 1) ? gpio_pkg::PB_MASK : gpio_pkg::FULL_MASK;
  endfunction

  function automatic logic [7:0] sel_mask(input int s);
    return (s == 3) ? gpio_pkg::PORT_B_FUNC_SEL_HIGH_MASK : gpio_pkg::FULL_MASK;
  endfunction

  function automatic logic [7:0] route_mask(input int r);
    logic [7:0] m;
    m = gpio_pkg::ROUTE0_MASK;
    if (r == 1) begin
      m = gpio_pkg::ROUTE1_MASK;
    end else if (r == 2) begin
      m = gpio_pkg::ROUTE2_MASK;
    end else if (r == 3) begin
      m = gpio_pkg::ROUTE3_MASK;
    end else if (r == 4) begin
      m = gpio_pkg::ROUTE4_MASK;
    end
    return m;
  endfunction

  function automatic logic [7:0] data_rst(input int p);
    return (p == 1) ? gpio_pkg::RST_PB_DATA : gpio_pkg::RST_ONES;
  endfunction

  function automatic logic [7:0] dir_rst(input int p);
    return gpio_pkg::RST_ONES & port_mask(p);
  endfunction

  // ==========================================
  // Pin synchroniser.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sync1_reg <= 48'hffff_ffff_ffff;
      sync2_reg <= 48'hffff_ffff_ffff;
    end else begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
    end
  end

  // ==========================================
  // Port registers.
  always_ff @(posedge core_clk) begin
    for (int p = 0; p < gpio_pkg::NUM_PORTS; p++) begin
      if (sys_rst) begin
        pull_reg[p] <= gpio_pkg::RST_ZERO;
        data_reg[p] <= data_rst(p);
        dir_reg[p]  <= dir_rst(p);
      end else if (mem_wr) begin
        if (mem_addr == gpio_pkg::OFF_PA_PULL + 6'(3 * p)) begin
          pull_reg[p] <= mem_wdata & port_mask(p);
        end else if (mem_addr == gpio_pkg::OFF_PA_DATA + 6'(3 * p)) begin
          data_reg[p] <= mem_wdata & port_mask(p);
        end else if (mem_addr == gpio_pkg::OFF_PA_DIR + 6'(3 * p)) begin
          dir_reg[p] <= mem_wdata & port_mask(p);
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wake_reg <= gpio_pkg::RST_ZERO;
    end else if (mem_wr && mem_addr == gpio_pkg::OFF_PA_WAKE) begin
      wake_reg <= mem_wdata;
    end
  end

  // ==========================================
  // Function selectors and input routes.
  always_ff @(posedge core_clk) begin
    for (int s = 0; s < gpio_pkg::NUM_SEL; s++) begin
      if (sys_rst) begin
        sel_reg[s] <= gpio_pkg::RST_ZERO;
      end else if (mem_wr && mem_addr == gpio_pkg::OFF_SEL_BASE + 6'(s)) begin
        sel_reg[s] <= mem_wdata & sel_mask(s);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    for (int r = 0; r < gpio_pkg::NUM_ROUTE; r++) begin
      if (sys_rst) begin
        route_reg[r] <= gpio_pkg::RST_ZERO;
      end else if (mem_wr && mem_addr == gpio_pkg::OFF_ROUTE_BASE + 6'(r)) begin
        route_reg[r] <= mem_wdata & route_mask(r);
      end
    end
  end

  // ==========================================
  // Read path.
  always_comb begin
    rdata_next = 8'h00;
    for (int p = 0; p < gpio_pkg::NUM_PORTS; p++) begin
      if (mem_addr == gpio_pkg::OFF_PA_PULL + 6'(3 * p)) begin
        rdata_next = pull_reg[p];
      end else if (mem_addr == gpio_pkg::OFF_PA_DATA + 6'(3 * p)) begin
        rdata_next = ((dir_reg[p] & sync2_reg[8*p +: 8]) | (~dir_reg[p] & data_reg[p])) & port_mask(p);
      end else if (mem_addr == gpio_pkg::OFF_PA_DIR + 6'(3 * p)) begin
        rdata_next = dir_reg[p];
      end
    end
    if (mem_addr == gpio_pkg::OFF_PA_WAKE) begin
      rdata_next = wake_reg;
    end
    for (int s = 0; s < gpio_pkg::NUM_SEL; s++) begin
      if (mem_addr == gpio_pkg::OFF_SEL_BASE + 6'(s)) begin
        rdata_next = sel_reg[s];
      end
    end
    for (int r = 0; r < gpio_pkg::NUM_ROUTE; r++) begin
      if (mem_addr == gpio_pkg::OFF_ROUTE_BASE + 6'(r)) begin
        rdata_next = route_reg[r];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mem_rdata <= 8'h00;
    end else if (mem_rd) begin
      mem_rdata <= rdata_next;
    end
  end

  // ==========================================
  // Pin drivers.
  always_comb begin
    out_next  = 48'h0;
    oe_n_next = 48'hffff_ffff_ffff;
    pull_next = 48'h0;
    for (int p = 0; p < gpio_pkg::NUM_PORTS; p++) begin
      out_next[8*p +: 8]  = data_reg[p] & port_mask(p);
      oe_n_next[8*p +: 8] = dir_reg[p] | ~port_mask(p);
      pull_next[8*p +: 8] = pull_reg[p] & dir_reg[p];
    end
    if (sel_reg[0][gpio_pkg::PIN1_LSB +: 2] == gpio_pkg::SEL_F1) begin
      out_next[1] = serial_out;
    end else if (sel_reg[0][gpio_pkg::PIN1_LSB +: 2] == gpio_pkg::SEL_F2) begin
      out_next[1] = timer0_output;
    end else if (sel_reg[0][gpio_pkg::PIN1_LSB +: 2] == gpio_pkg::SEL_F3) begin
      oe_n_next[1] = 1'b1;
      pull_next[1] = 1'b0;
    end
    if (sel_reg[0][gpio_pkg::PIN0_LSB +: 2] == gpio_pkg::SEL_F3) begin
      oe_n_next[0] = 1'b1;
      pull_next[0] = 1'b0;
    end
    if (sel_reg[0][gpio_pkg::PIN2_LSB +: 2] == gpio_pkg::SEL_F3) begin
      oe_n_next[2] = 1'b1;
      pull_next[2] = 1'b0;
    end
    if (sel_reg[0][gpio_pkg::PIN3_LSB +: 2] == gpio_pkg::SEL_F2) begin
      oe_n_next[3] = 1'b1;
      pull_next[3] = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pin_out     <= {gpio_pkg::RST_ONES, gpio_pkg::RST_ONES, gpio_pkg::RST_ONES, gpio_pkg::RST_ONES,
                      gpio_pkg::RST_PB_DATA, gpio_pkg::RST_ONES};
      pin_oe_n    <= 48'hffff_ffff_ffff;
      pin_pull_en <= 48'h0;
    end else begin
      pin_out     <= out_next;
      pin_oe_n    <= oe_n_next;
      pin_pull_en <= pull_next;
    end
  end

  // ==========================================
  // Analog enables of the first port and peripheral input routing from the first and fourth ports.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pa3_vref_en        <= 1'b0;
      pa2_an4_en         <= 1'b0;
      pa1_an0_en         <= 1'b0;
      pa0_an5_en         <= 1'b0;
      timer0_clock_input <= 1'b0;
      serial_in          <= 1'b0;
    end else begin
      pa3_vref_en <= sel_reg[0][gpio_pkg::PIN3_LSB +: 2] == gpio_pkg::SEL_F2;
      pa2_an4_en  <= sel_reg[0][gpio_pkg::PIN2_LSB +: 2] == gpio_pkg::SEL_F3;
      pa1_an0_en  <= sel_reg[0][gpio_pkg::PIN1_LSB +: 2] == gpio_pkg::SEL_F3;
      pa0_an5_en  <= sel_reg[0][gpio_pkg::PIN0_LSB +: 2] == gpio_pkg::SEL_F3;
      if (route_reg[1][gpio_pkg::ROUTE1_TCK0]) begin
        timer0_clock_input <= sync2_reg[28];
      end else begin
        timer0_clock_input <= sync2_reg[3];
      end
      if (route_reg[3][gpio_pkg::ROUTE3_SDI]) begin
        serial_in <= sync2_reg[26];
      end else begin
        serial_in <= sync2_reg[3];
      end
    end
  end

  // ==========================================
  // Wake-up.
  gpio_wake_detect u_wake (
    .core_clk    (core_clk),
    .sys_rst     (sys_rst),
    .pin_level   (sync2_reg[7:0]),
    .wake_enable (wake_reg),
    .low_power   (low_power),
    .wake_req    (wake_req)
  );
endmodule

// ==== design/gpio_wake_detect.sv ====
// Falling-edge wake-up detector for the first port.
`timescale 1ns/100ps
module gpio_wake_detect (
  input  wire logic       core_clk,    // System clock.
  input  wire logic       sys_rst,     // Synchronous reset, active high.
  input  wire logic [7:0] pin_level,   // Synchronised pin levels.
  input  wire logic [7:0] wake_enable, // Per-pin wake enables.
  input  wire logic       low_power,   // Core is in sleep or idle.
  output logic            wake_req     // Combined wake-up request.
);
  logic [7:0] prev_reg;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      prev_reg <= 8'hff;
    end else begin
      prev_reg <= pin_level;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wake_req <= 1'b0;
    end else begin
      wake_req <= low_power && (|(prev_reg & ~pin_level & wake_enable));
    end
  end
endmodule
